/* File: scu_defs.svh */
`ifndef SCU_DEFS_SVH
`define SCU_DEFS_SVH

// ****************************************
// Constants
// ****************************************
`define SCU_NCH 4
`define SCU_PER_U0_BIT 2
`define SCU_PER_U1_BIT 3
`define SCU_PER_RST 8'h00
`define SCU_UNIT1_CH 4'h8
`define SCU_LVL_RST 4'hF
`define SCU_PSC_MAX 4'hB
`define SCU_PSC_RST 4'h0
`define SCU_DIV_MIN 7'h01
`define SCU_DIV_RST 7'h01
`define SCU_LEN8 4'h8
`define SCU_LEN7 4'h7
`endif

/* File: scu_pkg.sv */
package scu_pkg;
    typedef enum logic [2:0] {
        SCU_MTX,
        SCU_MRX,
        SCU_MTRX,
        SCU_STX,
        SCU_SRX,
        SCU_STRX
    } scu_mode_t;
    typedef enum logic {
        SCU_IDLE,
        SCU_SHIFT
    } scu_st_t;
endpackage

/* File: scu_chan.sv */
`include "scu_defs.svh"
module scu_chan (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire scu_pkg::scu_mode_t mode_i,
    input wire logic len7_i,
    input wire logic lsb_i,
    input wire logic inv_i,
    input wire logic dap_i,
    input wire logic ckp_i,
    input wire logic cont_i,
    input wire logic [6:0] div_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rx_rd_i,
    input wire logic si_i,
    output logic sck_o,
    output logic so_o,
    output logic bff_o,
    output logic tsf_o,
    output logic irq_o,
    output logic [7:0] rx_o,
    output logic ovf_o
);
    import scu_pkg::*;

    scu_st_t st_q;
    logic [4:0] h_q;
    logic [6:0] dcnt_q;
    logic [7:0] sh_q;
    logic [7:0] buf_q;
    logic [7:0] rxs_q;
    logic rxf_q;
    logic [3:0] nbits;
    logic [4:0] last;
    logic [6:0] div_eff;
    logic half_end;
    logic master;
    logic rxmode;
    logic [2:0] idx;
    logic [2:0] sidx;
    logic [4:0] h_nx;
    logic base_low;

    assign nbits = len7_i ? `SCU_LEN7 : `SCU_LEN8;
    assign last = dap_i ? {nbits, 1'b0} : 5'({nbits, 1'b0} - 5'h01);
    assign div_eff = (div_i < `SCU_DIV_MIN) ? `SCU_DIV_MIN : div_i;
    assign half_end = tick_i && (dcnt_q == div_eff);
    assign master = (mode_i == SCU_MTX) || (mode_i == SCU_MRX) || (mode_i == SCU_MTRX);
    assign rxmode = (mode_i != SCU_MTX) && (mode_i != SCU_STX);
    assign idx = lsb_i ? h_q[3:1] : 3'(nbits - 4'h1 - {1'b0, h_q[3:1]});
    assign h_nx = 5'(h_q + 5'h01);
    assign sidx = lsb_i ? h_nx[3:1] : 3'(nbits - 4'h1 - {1'b0, h_nx[3:1]});
    assign base_low = dap_i ? h_q[0] : ~h_q[0];

    // ****************************************
    // Transfer sequencing
    // ****************************************
    // Slave modes never start here: their clock would come from the far end.
    always_ff @(posedge clk_i)
    begin
        irq_o <= 1'b0;
        if (srst_i || !run_i)
        begin
            st_q <= SCU_IDLE;
            h_q <= 5'h00;
            dcnt_q <= 7'h00;
            sh_q <= 8'h00;
        end
        else if (st_q == SCU_IDLE)
        begin
            dcnt_q <= 7'h00;
            if (bff_o && master)
            begin
                st_q <= SCU_SHIFT;
                sh_q <= buf_q;
                h_q <= 5'h00;
                irq_o <= cont_i;
            end
        end
        else if (tick_i)
        begin
            dcnt_q <= half_end ? 7'h00 : 7'(dcnt_q + 7'h01);
            if (half_end)
            begin
                if (h_q == last)
                begin
                    h_q <= 5'h00;
                    if (cont_i && bff_o)
                    begin
                        sh_q <= buf_q;
                        irq_o <= 1'b1;
                    end
                    else
                    begin
                        st_q <= SCU_IDLE;
                        irq_o <= !cont_i;
                    end
                end
                else
                begin
                    h_q <= h_nx;
                end
            end
        end
    end

    // ****************************************
    // Transmit buffer
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !run_i)
        begin
            bff_o <= 1'b0;
            buf_q <= 8'h00;
        end
        else if (wr_i)
        begin
            bff_o <= 1'b1;
            buf_q <= wdata_i;
        end
        else if ((st_q == SCU_IDLE && master) || (half_end && h_q == last && cont_i))
        begin
            bff_o <= 1'b0;
        end
    end

    // ****************************************
    // Pin drive and receive
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sck_o <= 1'b1;
            so_o <= 1'b1;
            tsf_o <= 1'b0;
        end
        else
        begin
            tsf_o <= (st_q == SCU_SHIFT);
            if (st_q == SCU_SHIFT)
            begin
                sck_o <= ckp_i ? base_low : ~base_low;
                so_o <= sh_q[idx] ^ inv_i;
            end
            else
            begin
                sck_o <= ~ckp_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i || !run_i)
        begin
            rxs_q <= 8'h00;
            rx_o <= 8'h00;
            rxf_q <= 1'b0;
            ovf_o <= 1'b0;
        end
        else
        begin
            if (st_q == SCU_SHIFT && half_end && h_q != last && h_nx[0])
            begin
                rxs_q[sidx] <= si_i ^ inv_i;
            end
            if (st_q == SCU_SHIFT && half_end && h_q == last && rxmode)
            begin
                rx_o <= rxs_q;
                rxf_q <= 1'b1;
                ovf_o <= ovf_o | rxf_q;
            end
            else if (rx_rd_i)
            begin
                rxf_q <= 1'b0;
            end
        end
    end
endmodule

/* File: scu_top.sv */
`include "scu_defs.svh"
module scu_top (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic per_wr_i,
    input wire logic [7:0] per_wdata_i,
    input wire logic psc_wr_i,
    input wire logic psc_unit_i,
    input wire logic [3:0] psc_wdata_i,
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_sel_i,
    input wire scu_pkg::scu_mode_t cfg_mode_i,
    input wire logic cfg_len7_i,
    input wire logic cfg_lsb_i,
    input wire logic cfg_inv_i,
    input wire logic cfg_dap_i,
    input wire logic cfg_ckp_i,
    input wire logic cfg_cont_i,
    input wire logic [6:0] cfg_div_i,
    input wire logic start_wr_i,
    input wire logic [3:0] start_wdata_i,
    input wire logic halt_wr_i,
    input wire logic [3:0] halt_wdata_i,
    input wire logic oe_wr_i,
    input wire logic [3:0] oe_wdata_i,
    input wire logic lvl_wr_i,
    input wire logic [3:0] lvl_ck_wdata_i,
    input wire logic [3:0] lvl_do_wdata_i,
    input wire logic tx_wr_i,
    input wire logic [1:0] tx_sel_i,
    input wire logic [7:0] tx_data_i,
    input wire logic [3:0] rx_rd_i,
    input wire logic [3:0] si_i,
    output logic [7:0] module_clock_enable_reg_o,
    output logic [3:0] channel_enable_status_o,
    output logic [3:0] channel_halt_bit_o,
    output logic [3:0] output_enable_per_channel_o,
    output logic [3:0] clock_out_level_bit_o,
    output logic [3:0] data_out_level_bit_o,
    output logic [3:0] port_release_o,
    output logic [3:0] buffer_full_flag_o,
    output logic [3:0] busy_o,
    output logic [3:0] transfer_irq_o,
    output logic [3:0][7:0] rx_data_o,
    output logic [3:0] overrun_o
);
    import scu_pkg::*;
    localparam logic [3:0] UNIT1_MAP = `SCU_UNIT1_CH;
    localparam logic [3:0] LVL_RST = `SCU_LVL_RST;

    // ****************************************
    // Unit clock gates and prescalers
    // ****************************************
    logic [7:0] per_q;
    logic [1:0] unit_clock_gate;
    logic [3:0] ch_gate;
    logic [3:0] psc_q [2];
    logic [10:0] pcnt_q [2];
    logic [1:0] tick_q;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            per_q <= `SCU_PER_RST;
        end
        else if (per_wr_i)
        begin
            per_q <= per_wdata_i;
        end
    end

    assign unit_clock_gate = {per_q[`SCU_PER_U1_BIT], per_q[`SCU_PER_U0_BIT]};
    assign module_clock_enable_reg_o = per_q;

    genvar u;
    generate
        for (u = 0; u < 2; u++)
        begin : g_unit
            logic [10:0] mask;
            assign mask = 11'((12'h001 << psc_q[u]) - 12'h001);
            always_ff @(posedge clk_i)
            begin
                if (srst_i || !unit_clock_gate[u])
                begin
                    psc_q[u] <= `SCU_PSC_RST;
                    pcnt_q[u] <= 11'h000;
                    tick_q[u] <= 1'b0;
                end
                else
                begin
                    if (psc_wr_i && psc_unit_i == 1'(u))
                    begin
                        // Values past the top divide are clamped, not wrapped.
                        psc_q[u] <= (psc_wdata_i > `SCU_PSC_MAX) ? `SCU_PSC_MAX : psc_wdata_i;
                    end
                    pcnt_q[u] <= 11'(pcnt_q[u] + 11'h001);
                    tick_q[u] <= ((pcnt_q[u] & mask) == mask);
                end
            end
        end
    endgenerate

    // ****************************************
    // Channel map
    // ****************************************
    // Channel 3 of this map is unit 1 channel 0; the other units' channels have
    // no three-wire function and are not built.
    genvar c;
    generate
        for (c = 0; c < `SCU_NCH; c++)
        begin : g_gate
            assign ch_gate[c] = UNIT1_MAP[c] ? unit_clock_gate[1] : unit_clock_gate[0];
        end
    endgenerate

    // ****************************************
    // Channel configuration
    // ****************************************
    scu_mode_t mode_q [`SCU_NCH];
    logic [3:0] len7_q;
    logic [3:0] lsb_q;
    logic [3:0] inv_q;
    logic [3:0] dap_q;
    logic [3:0] ckp_q;
    logic [3:0] cont_q;
    logic [6:0] div_q [`SCU_NCH];

    generate
        for (c = 0; c < `SCU_NCH; c++)
        begin : g_cfg
            always_ff @(posedge clk_i)
            begin
                if (srst_i || !ch_gate[c])
                begin
                    mode_q[c] <= SCU_MTX;
                    len7_q[c] <= 1'b0;
                    lsb_q[c] <= 1'b0;
                    inv_q[c] <= 1'b0;
                    dap_q[c] <= 1'b0;
                    ckp_q[c] <= 1'b0;
                    cont_q[c] <= 1'b0;
                    div_q[c] <= `SCU_DIV_RST;
                end
                else if (cfg_wr_i && cfg_sel_i == 2'(c))
                begin
                    mode_q[c] <= cfg_mode_i;
                    len7_q[c] <= cfg_len7_i;
                    lsb_q[c] <= cfg_lsb_i;
                    inv_q[c] <= cfg_inv_i;
                    dap_q[c] <= cfg_dap_i;
                    ckp_q[c] <= cfg_ckp_i;
                    cont_q[c] <= cfg_cont_i;
                    div_q[c] <= cfg_div_i;
                end
            end
        end
    endgenerate

    // ****************************************
    // Enable status and halt trigger
    // ****************************************
    logic [3:0] sts_q;
    logic [3:0] halt_q;

    generate
        for (c = 0; c < `SCU_NCH; c++)
        begin : g_sts
            always_ff @(posedge clk_i)
            begin
                if (srst_i || !ch_gate[c])
                begin
                    sts_q[c] <= 1'b0;
                    halt_q[c] <= 1'b0;
                end
                else
                begin
                    if (halt_q[c])
                    begin
                        sts_q[c] <= 1'b0;
                    end
                    else if (start_wr_i && start_wdata_i[c])
                    begin
                        sts_q[c] <= 1'b1;
                    end
                    if (halt_wr_i && halt_wdata_i[c])
                    begin
                        halt_q[c] <= 1'b1;
                    end
                    else if (!sts_q[c])
                    begin
                        halt_q[c] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign channel_enable_status_o = sts_q;
    assign channel_halt_bit_o = halt_q;

    // ****************************************
    // Output enable, pin levels and port release
    // ****************************************
    logic [3:0] oe_q;
    logic [3:0] ckl_q;
    logic [3:0] dol_q;
    logic [3:0] rel_q;
    logic [3:0] ch_sck;
    logic [3:0] ch_so;

    generate
        for (c = 0; c < `SCU_NCH; c++)
        begin : g_pin
            always_ff @(posedge clk_i)
            begin
                if (srst_i || !ch_gate[c])
                begin
                    oe_q[c] <= 1'b0;
                    ckl_q[c] <= LVL_RST[c];
                    dol_q[c] <= LVL_RST[c];
                    rel_q[c] <= 1'b1;
                end
                else
                begin
                    rel_q[c] <= !sts_q[c];
                    if (oe_wr_i)
                    begin
                        oe_q[c] <= oe_wdata_i[c];
                    end
                    if (sts_q[c])
                    begin
                        ckl_q[c] <= ch_sck[c];
                    end
                    else if (lvl_wr_i)
                    begin
                        ckl_q[c] <= lvl_ck_wdata_i[c];
                    end
                    if (sts_q[c] && oe_q[c])
                    begin
                        dol_q[c] <= ch_so[c];
                    end
                    else if (lvl_wr_i && !oe_q[c])
                    begin
                        dol_q[c] <= lvl_do_wdata_i[c];
                    end
                end
            end
        end
    endgenerate

    assign output_enable_per_channel_o = oe_q;
    assign clock_out_level_bit_o = ckl_q;
    assign data_out_level_bit_o = dol_q;
    assign port_release_o = rel_q;

    // ****************************************
    // Serial input synchronisers
    // ****************************************
    // Data in comes from off chip, so it passes two stages before any use.
    logic [3:0] si_s1_q;
    logic [3:0] si_s2_q;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            si_s1_q <= 4'hF;
            si_s2_q <= 4'hF;
        end
        else
        begin
            si_s1_q <= si_i;
            si_s2_q <= si_s1_q;
        end
    end

    // ****************************************
    // Channel engines
    // ****************************************
    generate
        for (c = 0; c < `SCU_NCH; c++)
        begin : g_ch
            scu_chan u_chan (
                .clk_i(clk_i),
                .srst_i(srst_i || !ch_gate[c]),
                .run_i(sts_q[c]),
                .tick_i(UNIT1_MAP[c] ? tick_q[1] : tick_q[0]),
                .mode_i(mode_q[c]),
                .len7_i(len7_q[c]),
                .lsb_i(lsb_q[c]),
                .inv_i(inv_q[c]),
                .dap_i(dap_q[c]),
                .ckp_i(ckp_q[c]),
                .cont_i(cont_q[c]),
                .div_i(div_q[c]),
                .wr_i(tx_wr_i && tx_sel_i == 2'(c) && ch_gate[c]),
                .wdata_i(tx_data_i),
                .rx_rd_i(rx_rd_i[c]),
                .si_i(si_s2_q[c]),
                .sck_o(ch_sck[c]),
                .so_o(ch_so[c]),
                .bff_o(buffer_full_flag_o[c]),
                .tsf_o(busy_o[c]),
                .irq_o(transfer_irq_o[c]),
                .rx_o(rx_data_o[c]),
                .ovf_o(overrun_o[c])
            );
        end
    endgenerate
endmodule

/* File: scu_chk.sv */
module scu_chk (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic halt_wr_i,
    input wire logic [3:0] halt_wdata_i,
    input wire logic lvl_wr_i,
    input wire logic [3:0] lvl_ck_wdata_i,
    input wire logic [3:0] lvl_do_wdata_i,
    input wire logic tx_wr_i,
    input wire logic [1:0] tx_sel_i,
    input wire logic [7:0] module_clock_enable_reg_o,
    input wire logic [3:0] channel_enable_status_o,
    input wire logic [3:0] channel_halt_bit_o,
    input wire logic [3:0] output_enable_per_channel_o,
    input wire logic [3:0] clock_out_level_bit_o,
    input wire logic [3:0] data_out_level_bit_o,
    input wire logic [3:0] port_release_o,
    input wire logic [3:0] buffer_full_flag_o,
    input wire logic [3:0] busy_o,
    input wire logic [3:0] transfer_irq_o
);
    logic [3:0] gate;
    logic [3:0] hz_q;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    assign gate = {module_clock_enable_reg_o[3], {3{module_clock_enable_reg_o[2]}}};
    // A halt written in the same cycle wins, so it is kept out of the pending set.
    always_ff @(posedge clk_i)
        hz_q <= channel_halt_bit_o & ~channel_enable_status_o & ~({4{halt_wr_i}} & halt_wdata_i);
    // ********************
    // Assertions
    // ********************
    rst_lvl_a: assert property ($fell(srst_i) |-> clock_out_level_bit_o == 4'hF &&
        data_out_level_bit_o == 4'hF && channel_enable_status_o == 4'h0)
        else $error("pins not idle after reset");
    stat_gate_a: assert property (!module_clock_enable_reg_o[2] &&
        !$past(module_clock_enable_reg_o[2]) |-> channel_enable_status_o[2:0] == 3'h0)
        else $error("channel runs with its unit gated");
    stat_fall_a: assert property ((($past(channel_enable_status_o) & ~channel_enable_status_o
        & $past(gate) & gate) & ~$past(channel_halt_bit_o)) == 4'h0)
        else $error("status cleared without halt");
    halt_stop_a: assert property (halt_wr_i && halt_wdata_i[1] && gate[1]
        |-> ##[1:3] !channel_enable_status_o[1])
        else $error("halt did not stop channel");
    halt_clr_a: assert property ((channel_halt_bit_o & hz_q) == 4'h0)
        else $error("halt bit not cleared");
    ck_level_a: assert property (lvl_wr_i && gate[2] && !channel_enable_status_o[2] |=>
        clock_out_level_bit_o[2] == $past(lvl_ck_wdata_i[2]))
        else $error("clock level write lost");
    do_level_a: assert property (lvl_wr_i && gate[3] && !output_enable_per_channel_o[3] |=>
        data_out_level_bit_o[3] == $past(lvl_do_wdata_i[3]))
        else $error("data level write lost");
    rel_idle_a: assert property (!channel_enable_status_o[1] [*3] |->
        port_release_o[1] && !busy_o[1])
        else $error("stopped channel not released");
    sck_rate_a: assert property (channel_enable_status_o[0] &&
        $past(channel_enable_status_o[0]) &&
        $changed(clock_out_level_bit_o[0]) |=> $stable(clock_out_level_bit_o[0]))
        else $error("serial clock too fast");
    tx_bff_a: assert property (tx_wr_i && tx_sel_i == 2'h0 && gate[0] &&
        channel_enable_status_o[0] |=> buffer_full_flag_o[0])
        else $error("buffer flag not set");
    cov_irq: cover property (transfer_irq_o[3]);
    cov_halt: cover property ((channel_halt_bit_o & ~channel_enable_status_o) != 4'h0);
    cov_lvl: cover property (lvl_wr_i && !channel_enable_status_o[0]);
endmodule

bind scu_top scu_chk u_chk (.clk_i, .srst_i, .halt_wr_i, .halt_wdata_i, .lvl_wr_i,
    .lvl_ck_wdata_i, .lvl_do_wdata_i, .tx_wr_i, .tx_sel_i, .module_clock_enable_reg_o,
    .channel_enable_status_o, .channel_halt_bit_o, .output_enable_per_channel_o,
    .clock_out_level_bit_o, .data_out_level_bit_o, .port_release_o, .buffer_full_flag_o,
    .busy_o, .transfer_irq_o);

/* File: scu_rx_peer.sv */
module scu_rx_peer (
    input wire logic ckp_i,
    input wire logic dap_i,
    input wire logic clr_i,
    input wire logic sck_i,
    input wire logic so_i,
    output logic [7:0] shift_o,
    output logic [4:0] cnt_o,
    output int per_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 100ps;
    realtime t_q;
    initial
    begin
        si_o = 1'b0;
        per_o = 0;
    end
    always @(posedge clr_i)
    begin
        shift_o <= 8'h00;
        cnt_o <= 5'h00;
        t_q = $realtime;
    end
    // The far side never holds its return line, so it changes on every clock edge.
    always @(sck_i)
    begin
        si_o <= ~si_o;
        if (sck_i === (dap_i ? ckp_i : ~ckp_i))
        begin
            shift_o <= {shift_o[6:0], so_i};
            cnt_o <= cnt_o + 5'h01;
            per_o <= int'($realtime - t_q);
            t_q = $realtime;
        end
    end
endmodule

/* File: scu_top_bench.sv */
`include "scu_defs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module scu_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import scu_pkg::*;
    localparam int PER = 0, PSC = 1, CFG = 2, GO = 3, HALT = 4, OE = 5, LVL = 6, TX = 7;
    logic clk_i = 0, srst_i = 1, psc_unit_i = 0, cfg_len7_i = 0, cfg_lsb_i = 0, cfg_inv_i = 0;
    logic cfg_dap_i = 0, cfg_ckp_i = 0, cfg_cont_i = 0, pk_clr = 0;
    logic per_wr_i, psc_wr_i, cfg_wr_i, start_wr_i, halt_wr_i, oe_wr_i, lvl_wr_i, tx_wr_i, pk_si;
    logic [7:0] wr = 8'h00, per_wdata_i = 8'h00, tx_data_i = 8'h00, d, pk_shift;
    logic [3:0] psc_wdata_i = 4'h0, start_wdata_i = 4'h0, halt_wdata_i = 4'h0, oe_wdata_i = 4'h0;
    logic [3:0] lvl_ck_wdata_i = 4'hF, lvl_do_wdata_i = 4'hF, rx_rd_i = 4'h0, si_i;
    logic [1:0] cfg_sel_i = 2'h0, tx_sel_i = 2'h0, sel = 2'h0;
    logic [6:0] cfg_div_i = 7'h01;
    logic [4:0] pk_cnt;
    scu_mode_t cfg_mode_i = SCU_MTX;
    logic [7:0] module_clock_enable_reg_o;
    logic [3:0] channel_enable_status_o, channel_halt_bit_o, output_enable_per_channel_o;
    logic [3:0] clock_out_level_bit_o, data_out_level_bit_o, port_release_o;
    logic [3:0] buffer_full_flag_o, busy_o, transfer_irq_o, overrun_o;
    logic [3:0][7:0] rx_data_o;
    int failures = 0, n_tests = 0, nirq = 0, pk_per;
    assign {per_wr_i, psc_wr_i, cfg_wr_i, start_wr_i, halt_wr_i, oe_wr_i, lvl_wr_i, tx_wr_i} = wr;
    assign si_i = {4{pk_si}};
    always #12.5 clk_i = ~clk_i;
    scu_top uut (.*);
    scu_rx_peer pk (.ckp_i(cfg_ckp_i), .dap_i(cfg_dap_i), .clr_i(pk_clr),
        .sck_i(clock_out_level_bit_o[sel]), .so_i(data_out_level_bit_o[sel]),
        .shift_o(pk_shift), .cnt_o(pk_cnt), .per_o(pk_per), .si_o(pk_si));
    always @(posedge clk_i)
        if (transfer_irq_o[sel] === 1'b1)
            nirq++;
    // ********************
    // Access tasks
    // ********************
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One strobe per call; data fields are loaded together so one task serves them all.
    task automatic w(input int k, input logic [7:0] v);
        @(posedge clk_i);
        wr <= 8'h80 >> k;
        {per_wdata_i, tx_data_i, lvl_do_wdata_i} <= {v, v, v[7:4]};
        {psc_wdata_i, start_wdata_i, halt_wdata_i, oe_wdata_i, lvl_ck_wdata_i} <= {5{v[3:0]}};
        {psc_unit_i, cfg_sel_i, tx_sel_i} <= {sel == 2'h3, sel, sel};
        @(posedge clk_i);
        wr <= 8'h00;
    endtask
    task automatic done(input logic [4:0] n);
        for (int j = 0; j < 2000; j++)
        begin
            @(posedge clk_i);
            if (pk_cnt == n && busy_o[sel] === 1'b0 && buffer_full_flag_o[sel] === 1'b0)
                break;
        end
        step(4);
    endtask
    function automatic logic [7:0] exp_bits(input logic [7:0] v);
        logic [7:0] e = 8'h00;
        int l = cfg_len7_i ? 7 : 8;
        for (int k = 0; k < l; k++)
            e = {e[6:0], (cfg_lsb_i ? v[k] : v[l - 1 - k]) ^ cfg_inv_i};
        return e;
    endfunction
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ********************
    // Tests
    // ********************
    initial
    begin
        #(20000 * 25);
        failures++;
        final_report;
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        step(2);
        `CHK(clock_out_level_bit_o, `SCU_LVL_RST)
        `CHK(data_out_level_bit_o, `SCU_LVL_RST)
        `CHK(port_release_o, 4'hF)
        `CHK(channel_enable_status_o, 4'h0)
        w(GO, 8'h0F);
        w(LVL, 8'h00);
        step(1);
        `CHK(channel_enable_status_o, 4'h0)
        `CHK(clock_out_level_bit_o, 4'hF)
        w(PER, 8'h0C);
        step(1);
        `CHK(module_clock_enable_reg_o, 8'h0C)
        step(4);
        w(PSC, 8'h01);
        sel = 2'h3;
        w(PSC, 8'h01);
        w(OE, 8'h00);
        w(LVL, 8'h00);
        step(1);
        `CHK(clock_out_level_bit_o, 4'h0)
        `CHK(data_out_level_bit_o, 4'h0)
        w(LVL, 8'hFF);
        for (int i = 0; i < 5; i++)
        begin
            sel = i[1:0];
            {cfg_len7_i, cfg_lsb_i, cfg_inv_i} <= {i[0], i[0] ^ i[1], i[0]};
            {cfg_dap_i, cfg_ckp_i, cfg_cont_i} <= {i[0], i[1], i[2]};
            cfg_mode_i <= (i == 4) ? SCU_MTRX : SCU_MTX;
            w(CFG, 8'h00);
            w(OE, 8'h0F);
            w(GO, 8'h01 << i[1:0]);
            step(3);
            pk_clr = 1'b1;
            #1 pk_clr = 1'b0;
            nirq = 0;
            d = 8'hC5 + i[7:0];
            w(TX, d);
            if (i == 4)
            begin
                step(4);
                w(TX, 8'h11);
                w(TX, 8'h5A);
                d = 8'h5A;
            end
            done(i == 4 ? 5'h10 : (i[0] ? 5'h07 : 5'h08));
            `CHK(pk_shift, exp_bits(d))
            `CHK(pk_per, 200)
            `CHK(nirq, (i == 4) ? 2 : 1)
            `CHK(overrun_o[sel], i == 4)
            if (i < 4)
                `CHK(rx_data_o[sel], 8'h00)
            w(HALT, 8'h01 << i[1:0]);
            step(3);
            `CHK(channel_enable_status_o[i[1:0]], 1'b0)
            `CHK(channel_halt_bit_o, 4'h0)
            `CHK(port_release_o[i[1:0]], 1'b1)
        end
        w(GO, 8'h01);
        w(PER, 8'h08);
        step(2);
        `CHK(channel_enable_status_o, 4'h0)
        `CHK(clock_out_level_bit_o[0], 1'b1)
        final_report;
    end
endmodule
